// File: core/vic_top.v
// vectored interrupt control: flags, edge inputs, priority, axi4-lite
// assumes pins and strobes synchronous to aclk, cpu core drives accept
//
// Chosen here: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`include "vic_consts.vh"
// What this block does
// R1: ten flags; two test sources never vector
// R2: fixed vector entries 0002h to 000eh
// R3: simultaneous requests granted level 1 first
// R4: flag set by source, cleared on service
// R5: enable one permits, zero blocks
// R6: request line when flag and enable set
// R7: active request line wakes from standby
// R8: flags reachable by bit and byte writes
// R9: software-set flag vectors like hardware
// R10: reset clears all flags and enables
// R11: edge inputs 0,1 use selected edge
// R12: edge input 2 rising edge only
// R13: edge input 4 either edge
// R14: internal strobes set internal flags
// R15: edge input 0 noise filtered
// R16: filter clock selected by bit 3
// R17: threshold two cpu or fx/64 periods
// R18: edge selects reset zero, nibble written
// R19: master enable bit 3, high source low bits
// R20: service status gates, raised on accept
// R21: shared vector: both enabled, none cleared
// R22: software masks before changing edge select
// R23: hardware set beats simultaneous clear
module vic_top (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        ce,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        interval_timer_source,
  input  wire        serial_done_source,
  input  wire        event_counter_match_source,
  input  wire        pulse_gen_match_source,
  input  wire        key_scan_source,
  input  wire        watch_tick_source,
  input  wire        filtered_edge_pin_source,
  input  wire        second_edge_pin_source,
  input  wire        rising_test_pin_source,
  input  wire        both_edge_pin_source,
  input  wire        cpu_accept,
  input  wire        cpu_return,
  input  wire [1:0]  cpu_ret_status,
  input  wire        cpu_ei,
  input  wire        cpu_di,
  output reg         vec_req_ff,
  output reg  [2:0]  vec_level_ff,
  output reg  [15:0] vec_addr_ff,
  output reg         wake_ff,
  output reg  [1:0]  service_status_ff,
  output reg  [1:0]  saved_status_ff
);
  // ==========================================
  // state
  reg  [9:0]  request_flag_ff;
  reg  [9:0]  source_enable_flag_ff;
  reg  [3:0]  edge_select_reg_a_ff;
  reg  [3:0]  edge_select_reg_b_ff;
  reg  [3:0]  priority_select_register_ff;
  reg  [7:0]  awaddr_ff;
  reg  [31:0] wdata_ff;
  reg  [3:0]  wstrb_ff;
  reg         aw_held_ff;
  reg         w_held_ff;
  reg  [9:0]  nxt_request_flag;
  reg  [9:0]  nxt_source_enable_flag;
  reg  [3:0]  nxt_priority_select;
  reg  [1:0]  nxt_service_status;
  reg  [9:0]  acc_clr;
  reg  [7:1]  lines;
  reg         nxt_vec_req;
  reg  [2:0]  nxt_vec_level;
  reg  [15:0] nxt_vec_addr;
  reg  [31:0] rd_data;
  reg         rd_hit;
  reg         wr_hit;
  integer     k;
  wire        filt_level;
  wire        e0_pulse;
  wire        e1_pulse;
  wire        e2_pulse;
  wire        e4_pulse;
  wire [9:0]  hw_set;
  wire [9:0]  wmask = {{2{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
  wire [9:0]  wval  = wdata_ff[9:0] & wmask;
  wire        wr_fire = aw_held_ff & w_held_ff & ~s_axi_bvalid;
  wire        ar_fire = s_axi_arvalid & s_axi_arready;
  wire        acc_fire = cpu_accept & vec_req_ff;
  wire [1:0]  e1_mode = edge_select_reg_b_ff[1:0];

  // ==========================================
  // edge inputs
  // edge 0 filtered, sample clock cpu or fx/64 by bit 3
  vic_noise_filter u_filt0 (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .ce       (ce),
    .slow_sel (edge_select_reg_a_ff[`VIC_ES_SLOW]), // R16 R17
    .din      (filtered_edge_pin_source),
    .dout_ff  (filt_level)                       // R15
  );
  vic_edge_det u_e0 (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .ce       (ce),
    .din      (filt_level),
    .mode     (edge_select_reg_a_ff[1:0]),       // R11
    .pulse_ff (e0_pulse)
  );
  vic_edge_det u_e1 (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .ce       (ce),
    .din      (second_edge_pin_source),
    .mode     (e1_mode),                         // R11
    .pulse_ff (e1_pulse)
  );
  vic_edge_det u_e2 (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .ce       (ce),
    .din      (rising_test_pin_source),
    .mode     (`VIC_EDGE_RISE),                  // R12
    .pulse_ff (e2_pulse)
  );
  vic_edge_det u_e4 (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .ce       (ce),
    .din      (both_edge_pin_source),
    .mode     (`VIC_EDGE_BOTH),                  // R13
    .pulse_ff (e4_pulse)
  );

  // hardware set sources, internal strobes and edges
  assign hw_set[`VIC_SRC_BT]  = interval_timer_source;      // R14
  assign hw_set[`VIC_SRC_E4]  = e4_pulse;
  assign hw_set[`VIC_SRC_E0]  = e0_pulse;
  assign hw_set[`VIC_SRC_E1]  = e1_pulse;
  assign hw_set[`VIC_SRC_CSI] = serial_done_source;         // R14
  assign hw_set[`VIC_SRC_T0]  = event_counter_match_source; // R14
  assign hw_set[`VIC_SRC_TPG] = pulse_gen_match_source;     // R14
  assign hw_set[`VIC_SRC_KS]  = key_scan_source;            // R14
  assign hw_set[`VIC_SRC_W]   = watch_tick_source;          // R14
  assign hw_set[`VIC_SRC_E2]  = e2_pulse;

  // ==========================================
  // clear on service; shared slot clears only a lone enabled source
  always @* begin
    acc_clr = 10'h000;
    if (acc_fire) begin
      if (vec_level_ff == 3'd1) begin
        if (!(source_enable_flag_ff[`VIC_SRC_BT] & source_enable_flag_ff[`VIC_SRC_E4])) begin
          acc_clr[`VIC_SRC_BT] = source_enable_flag_ff[`VIC_SRC_BT]; // R4
          acc_clr[`VIC_SRC_E4] = source_enable_flag_ff[`VIC_SRC_E4]; // R4
        end                                                          // R21
      end else begin
        acc_clr[vec_level_ff] = 1'b1; // R4
      end
    end
  end

  // ==========================================
  // next flags; software write first, then clears, then hardware sets
  always @* begin
    wr_hit = 1'b1;
    nxt_request_flag = request_flag_ff;
    nxt_source_enable_flag = source_enable_flag_ff;
    nxt_priority_select = priority_select_register_ff;
    nxt_service_status = service_status_ff;
    if (wr_fire) begin
      case (awaddr_ff)
        `VIC_OFF_REQ: nxt_request_flag = (request_flag_ff & ~wmask) | wval; // R8 R9
        `VIC_OFF_REQ_SET: nxt_request_flag = request_flag_ff | wval;        // R8
        `VIC_OFF_REQ_CLR: nxt_request_flag = request_flag_ff & ~wval;       // R8
        `VIC_OFF_ENA: nxt_source_enable_flag = (source_enable_flag_ff & ~wmask) | wval;
        `VIC_OFF_ENA_SET: nxt_source_enable_flag = source_enable_flag_ff | wval;
        `VIC_OFF_ENA_CLR: nxt_source_enable_flag = source_enable_flag_ff & ~wval;
        `VIC_OFF_ESA, `VIC_OFF_ESB: wr_hit = 1'b1;
        `VIC_OFF_PRI: begin
          if (wstrb_ff[0]) begin
            nxt_priority_select = wdata_ff[3:0]; // R19
          end
        end
        `VIC_OFF_STS: begin
          if (wstrb_ff[0] && wdata_ff[1:0] != 2'h3) begin
            nxt_service_status = wdata_ff[1:0]; // R20
          end
        end
        default: wr_hit = 1'b0;
      endcase
    end
    // instruction side of master enable
    if (cpu_ei) begin
      nxt_priority_select[`VIC_PRI_IME] = 1'b1; // R19
    end
    if (cpu_di) begin
      nxt_priority_select[`VIC_PRI_IME] = 1'b0; // R19
    end
    // accept raises one level, return loads the status given on cpu_ret_status
    if (acc_fire) begin
      nxt_service_status = (service_status_ff == `VIC_ST_ALL) ? `VIC_ST_HIGH : `VIC_ST_NONE; // R20
    end else if (cpu_return) begin
      nxt_service_status = cpu_ret_status; // R20
    end
    // hardware set wins over any clear in the same cycle
    nxt_request_flag = (nxt_request_flag & ~acc_clr) | hw_set; // R23
  end

  // ==========================================
  // request lines and fixed priority on next-state values
  // next values avoid a stale request right after an accept
  always @* begin
    lines[1] = (nxt_request_flag[`VIC_SRC_BT] & nxt_source_enable_flag[`VIC_SRC_BT])
             | (nxt_request_flag[`VIC_SRC_E4] & nxt_source_enable_flag[`VIC_SRC_E4]); // R21
    for (k = 2; k <= 7; k = k + 1) begin
      lines[k] = nxt_request_flag[k] & nxt_source_enable_flag[k]; // R5 R6
    end
    nxt_vec_req = 1'b0;
    nxt_vec_level = 3'd0;
    // test sources bits 8,9 take no part here
    for (k = 7; k >= 1; k = k - 1) begin
      if (lines[k] && nxt_priority_select[`VIC_PRI_IME] &&
          (nxt_service_status == `VIC_ST_ALL ||
           (nxt_service_status == `VIC_ST_HIGH && nxt_priority_select[2:0] == k[2:0]))) begin
        nxt_vec_req = 1'b1;     // R1 R6 R20
        nxt_vec_level = k[2:0]; // R3
      end
    end
    case (nxt_vec_level)
      3'd1: nxt_vec_addr = `VIC_VEC_L1; // R2
      3'd2: nxt_vec_addr = `VIC_VEC_L2;
      3'd3: nxt_vec_addr = `VIC_VEC_L3;
      3'd4: nxt_vec_addr = `VIC_VEC_L4;
      3'd5: nxt_vec_addr = `VIC_VEC_L5;
      3'd6: nxt_vec_addr = `VIC_VEC_L6;
      3'd7: nxt_vec_addr = `VIC_VEC_L7;
      default: nxt_vec_addr = 16'h0000;
    endcase
  end

  // ==========================================
  // control state
  always @(posedge aclk) begin
    if (!aresetn) begin
      request_flag_ff <= `VIC_RST_REQ;                 // R10
      source_enable_flag_ff <= `VIC_RST_ENA;           // R10
      edge_select_reg_a_ff <= `VIC_RST_ES;             // R18
      edge_select_reg_b_ff <= `VIC_RST_ES;             // R18
      priority_select_register_ff <= `VIC_RST_PRI;     // R19
      service_status_ff <= `VIC_RST_STS;
      saved_status_ff <= `VIC_RST_STS;
      vec_req_ff <= 1'b0;
      vec_level_ff <= 3'd0;
      vec_addr_ff <= 16'h0000;
      wake_ff <= 1'b0;
    end else if (ce) begin
      request_flag_ff <= nxt_request_flag;
      source_enable_flag_ff <= nxt_source_enable_flag;
      priority_select_register_ff <= nxt_priority_select;
      service_status_ff <= nxt_service_status;
      if (acc_fire) begin
        saved_status_ff <= service_status_ff; // R20
      end
      // nibble-wide writes only
      if (wr_fire && wstrb_ff[0] && awaddr_ff == `VIC_OFF_ESA) begin
        edge_select_reg_a_ff <= wdata_ff[3:0]; // R18
      end
      if (wr_fire && wstrb_ff[0] && awaddr_ff == `VIC_OFF_ESB) begin
        edge_select_reg_b_ff <= wdata_ff[3:0]; // R18
      end
      vec_req_ff <= nxt_vec_req;
      vec_level_ff <= nxt_vec_level;
      vec_addr_ff <= nxt_vec_addr;
      // wake ignores master enable and service status
      wake_ff <= |lines; // R7
    end
  end

  // ==========================================
  // axi4-lite write channel, one write in flight
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `VIC_RESP_OKAY;
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_ff <= s_axi_awaddr;
        aw_held_ff <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
        w_held_ff <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `VIC_RESP_OKAY : `VIC_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ==========================================
  // read mux; set/clear aliases read back the live word
  always @* begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `VIC_OFF_REQ, `VIC_OFF_REQ_SET, `VIC_OFF_REQ_CLR:
        rd_data = {22'h0, request_flag_ff};
      `VIC_OFF_ENA, `VIC_OFF_ENA_SET, `VIC_OFF_ENA_CLR:
        rd_data = {22'h0, source_enable_flag_ff};
      `VIC_OFF_ESA: rd_data = {28'h0000000, edge_select_reg_a_ff};
      `VIC_OFF_ESB: rd_data = {28'h0000000, edge_select_reg_b_ff};
      `VIC_OFF_PRI: rd_data = {28'h0000000, priority_select_register_ff};
      `VIC_OFF_STS: rd_data = {28'h0000000, saved_status_ff, service_status_ff};
      `VIC_OFF_LINES: rd_data = {23'h0, wake_ff, lines, 1'b0};
      default: begin
        rd_data = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
  end

  // axi4-lite read channel, data one cycle after address
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `VIC_RESP_OKAY;
    end else if (ce) begin
      if (ar_fire) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_data;
        s_axi_rresp <= rd_hit ? `VIC_RESP_OKAY : `VIC_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule // vic_top

// File: core/vic_consts.vh
// constants for the vectored interrupt control block
// assumes inclusion by every core file of the block
`ifndef VIC_CONSTS_VH
`define VIC_CONSTS_VH
// ====
// source bit positions in request and enable words
`define VIC_SRC_BT    0
`define VIC_SRC_E4    1
`define VIC_SRC_E0    2
`define VIC_SRC_E1    3
`define VIC_SRC_CSI   4
`define VIC_SRC_T0    5
`define VIC_SRC_TPG   6
`define VIC_SRC_KS    7
`define VIC_SRC_W     8
`define VIC_SRC_E2    9
`define VIC_NSRC      10
// ====
// register byte offsets
`define VIC_OFF_REQ     8'h00
`define VIC_OFF_ENA     8'h04
`define VIC_OFF_ESA     8'h08
`define VIC_OFF_ESB     8'h0c
`define VIC_OFF_PRI     8'h10
`define VIC_OFF_STS     8'h14
`define VIC_OFF_LINES   8'h18
`define VIC_OFF_REQ_SET 8'h20
`define VIC_OFF_REQ_CLR 8'h24
`define VIC_OFF_ENA_SET 8'h28
`define VIC_OFF_ENA_CLR 8'h2c
// ====
// reset values
`define VIC_RST_REQ 10'h000
`define VIC_RST_ENA 10'h000
`define VIC_RST_ES  4'h0
`define VIC_RST_PRI 4'h0
`define VIC_RST_STS 2'h0
// ====
// fields
`define VIC_PRI_IME   3
`define VIC_ES_SLOW   3
`define VIC_EDGE_RISE 2'h0
`define VIC_EDGE_FALL 2'h1
`define VIC_EDGE_BOTH 2'h2
`define VIC_EDGE_NONE 2'h3
`define VIC_ST_ALL    2'h0
`define VIC_ST_HIGH   2'h1
`define VIC_ST_NONE   2'h2
// ====
// vector table entries per level
`define VIC_VEC_L1 16'h0002
`define VIC_VEC_L2 16'h0004
`define VIC_VEC_L3 16'h0006
`define VIC_VEC_L4 16'h0008
`define VIC_VEC_L5 16'h000a
`define VIC_VEC_L6 16'h000c
`define VIC_VEC_L7 16'h000e
// ====
// filter timing: fx taken as aclk, slow sample is fx/64
`define VIC_FX_DIV      64
`define VIC_FX_DIV_LAST 6'h3f
`define VIC_FILT_PERIODS 2
// ====
// bus answers
`define VIC_RESP_OKAY   2'h0
`define VIC_RESP_SLVERR 2'h2
`endif

// File: core/vic_edge_det.v
// edge detector with selectable edge, one-cycle pulse out
// assumes din synchronous to aclk
`timescale 1ns/1ps
`include "vic_consts.vh"
module vic_edge_det (
  input  wire       aclk,
  input  wire       aresetn,
  input  wire       ce,
  input  wire       din,
  input  wire [1:0] mode,
  output reg        pulse_ff
);
  reg prev_ff;
  reg valid_ff;
  wire rise = din & ~prev_ff;
  wire fall = ~din & prev_ff;
  reg  hit;
  // ==========================================
  // edge select
  always @* begin
    case (mode)
      `VIC_EDGE_RISE: hit = rise;
      `VIC_EDGE_FALL: hit = fall;
      `VIC_EDGE_BOTH: hit = rise | fall;
      default:        hit = 1'b0;
    endcase
  end
  // first sample after reset only primes prev, no spurious edge
  always @(posedge aclk) begin
    if (!aresetn) begin
      prev_ff  <= 1'b0;
      valid_ff <= 1'b0;
      pulse_ff <= 1'b0;
    end else if (ce) begin
      prev_ff  <= din;
      valid_ff <= 1'b1;
      pulse_ff <= hit & valid_ff;
    end
  end
endmodule // vic_edge_det

// File: core/vic_noise_filter.v
// sampling noise filter, output follows input after two equal samples
// assumes din synchronous to aclk; fx taken as aclk
`timescale 1ns/1ps
`include "vic_consts.vh"
module vic_noise_filter (
  input  wire aclk,
  input  wire aresetn,
  input  wire ce,
  input  wire slow_sel,
  input  wire din,
  output reg  dout_ff
);
  reg [5:0] pre_ff;
  reg       s1_ff;
  reg       s2_ff;
  wire      tick = ~slow_sel | (pre_ff == `VIC_FX_DIV_LAST);
  // ==========================================
  // prescaler and sampler; level accepted once two samples agree
  always @(posedge aclk) begin
    if (!aresetn) begin
      pre_ff  <= 6'h00;
      s1_ff   <= 1'b0;
      s2_ff   <= 1'b0;
      dout_ff <= 1'b0;
    end else if (ce) begin
      pre_ff <= pre_ff + 6'h01;
      if (tick) begin
        s1_ff <= din;
        s2_ff <= s1_ff;
        if (s1_ff == s2_ff) begin
          dout_ff <= s2_ff;
        end
      end
    end
  end
endmodule // vic_noise_filter

// File: testbench/vic_top_props.sv
// checker for the interrupt control top: request outputs, status, bus answers
// assumes one clock aclk and a synchronous active-low aresetn
`timescale 1ns/1ps
module vic_top_props (
  input wire        aclk,
  input wire        aresetn,
  input wire        ce,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire        cpu_accept,
  input wire        cpu_return,
  input wire [1:0]  cpu_ret_status,
  input wire        vec_req_ff,
  input wire [2:0]  vec_level_ff,
  input wire [15:0] vec_addr_ff,
  input wire        wake_ff,
  input wire [1:0]  service_status_ff,
  input wire [1:0]  saved_status_ff
);
  // ====
  // request outputs
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_vec_addr_map: assert property (vec_req_ff |->
    vec_level_ff != 3'h0 && vec_addr_ff == {12'h000, vec_level_ff, 1'b0})
    else $error("vector address does not follow level");
  a_idle_zero: assert property (!vec_req_ff |->
    vec_level_ff == 3'h0 && vec_addr_ff == 16'h0000)
    else $error("level or address shown without request");
  a_req_wakes: assert property (vec_req_ff |-> wake_ff)
    else $error("request without wake");
  a_status_blocks: assert property (service_status_ff == 2'h2 |-> !vec_req_ff)
    else $error("request offered in status two");
  // ====
  // service status
  a_accept_raise: assert property (ce && vec_req_ff && cpu_accept && !cpu_return |=>
    service_status_ff == $past(service_status_ff) + 2'h1 &&
    saved_status_ff == $past(service_status_ff))
    else $error("accept did not raise status");
  a_return_restore: assert property (ce && cpu_return && !cpu_accept &&
    cpu_ret_status != 2'h3 |=> service_status_ff == $past(cpu_ret_status))
    else $error("return did not restore status");
  // ====
  // bus answers
  a_write_answer: assert property (ce && s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (ce && s_axi_arvalid && s_axi_arready |->
    ##[1:2] s_axi_rvalid)
    else $error("read data late");
endmodule // vic_top_props

bind vic_top vic_top_props vic_top_props_i (.*);

// File: testbench/vic_cpu_model.sv
// cpu sequencer model: accepts vectored requests, services, returns
// assumes the design's request outputs are registered on aclk
`timescale 1ns/1ps
module vic_cpu_model (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        go,
  input  wire        vec_req_ff,
  input  wire [2:0]  vec_level_ff,
  input  wire [15:0] vec_addr_ff,
  input  wire [1:0]  saved_status_ff,
  output reg         cpu_accept,
  output reg         cpu_return,
  output reg  [1:0]  cpu_ret_status,
  output reg  [2:0]  lvl_ff,
  output reg  [15:0] addr_ff,
  output reg  [7:0]  n_ff
);
  reg [2:0] busy_ff;
  // ====
  // accept, short service, return with the saved status
  always @(posedge aclk) begin
    cpu_accept <= 1'b0;
    cpu_return <= 1'b0;
    if (!aresetn) begin
      busy_ff <= 3'h0;
      n_ff <= 8'h00;
      cpu_ret_status <= 2'h0;
    end else if (busy_ff != 3'h0) begin
      busy_ff <= busy_ff - 3'h1;
      if (busy_ff == 3'h2) cpu_ret_status <= saved_status_ff;
      if (busy_ff == 3'h1) cpu_return <= 1'b1;
    end else if (go && vec_req_ff) begin
      // only ever accepts an offered request, one pulse
      cpu_accept <= 1'b1;
      lvl_ff <= vec_level_ff;
      addr_ff <= vec_addr_ff;
      n_ff <= n_ff + 8'h01;
      busy_ff <= 3'h5;
    end
  end
endmodule // vic_cpu_model

// File: testbench/vic_top_tb.sv
// self-checking bench for vic_top over axi4-lite, pins, strobes and cpu model
// assumes vic_consts.vh on the include path
`timescale 1ns/1ps
`include "vic_consts.vh"
module vic_top_tb;
  logic        aclk, aresetn, ce, go, cpu_accept, cpu_return, cpu_ei, cpu_di;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, n_ff;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb, pin;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        vec_req_ff, wake_ff;
  logic [1:0]  s_axi_bresp, s_axi_rresp, cpu_ret_status, service_status_ff, saved_status_ff, r;
  logic [2:0]  vec_level_ff, lvl_ff;
  logic [15:0] vec_addr_ff, addr_ff;
  logic [5:0]  stb;
  int          err_total, checks_done;
  int          sb [6] = '{0, 4, 5, 6, 7, 8};
  vic_top vic_top_i (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .interval_timer_source(stb[0]),
    .serial_done_source(stb[1]), .event_counter_match_source(stb[2]),
    .pulse_gen_match_source(stb[3]), .key_scan_source(stb[4]), .watch_tick_source(stb[5]),
    .filtered_edge_pin_source(pin[0]), .second_edge_pin_source(pin[1]),
    .rising_test_pin_source(pin[2]), .both_edge_pin_source(pin[3]), .cpu_accept,
    .cpu_return, .cpu_ret_status, .cpu_ei, .cpu_di, .vec_req_ff, .vec_level_ff,
    .vec_addr_ff, .wake_ff, .service_status_ff, .saved_status_ff);
  vic_cpu_model vic_cpu_model_i (.*);
  // ====
  // clock, compare, verdict
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ====
  // bus master; s strobes in the landing cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [5:0] s = 6'h00);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      stb <= (s_axi_awready && s_axi_awvalid) ? s : 6'h00;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(d, e);
    chk(r, `VIC_RESP_OKAY);
  endtask
  // pin levels, then flags read and cleared
  task automatic step(input logic [3:0] v, input logic [31:0] e);
    @(posedge aclk);
    pin <= v;
    repeat (8) @(posedge aclk);
    rdc(`VIC_OFF_REQ, e);
    wr(`VIC_OFF_REQ_CLR, 32'h3ff);
  endtask
  task automatic master_enable(input logic on);
    @(posedge aclk);
    cpu_ei <= on;
    cpu_di <= !on;
    @(posedge aclk);
    cpu_ei <= 1'b0;
    cpu_di <= 1'b0;
  endtask
  // watchdog: the run needs about a thousand cycles
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    summarize;
  end
  // ====
  // main sequence
  initial begin
    {aresetn, go, cpu_ei, cpu_di, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, stb, pin, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {ce, s_axi_wstrb} = 5'h1f;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 7; i++) rdc(8'(4 * i), 32'h0);
    rd(8'h3c);
    chk(r, `VIC_RESP_SLVERR);
    wr(8'h40, 32'h1);
    chk(r, `VIC_RESP_SLVERR);
    wr(`VIC_OFF_ENA_SET, 32'h3fe);
    for (int i = 0; i < 6; i++) begin
      @(posedge aclk);
      stb <= 6'h01 << i;
      @(posedge aclk);
      stb <= 6'h00;
      rdc(`VIC_OFF_REQ, 32'h1 << sb[i]);
      wr(`VIC_OFF_REQ_CLR, 32'h1 << sb[i]);
    end
    // edge inputs, fast filter sampling
    wr(`VIC_OFF_ESB, 32'h1f);
    rdc(`VIC_OFF_ESB, 32'hf);
    wr(`VIC_OFF_ESB, {30'h0, `VIC_EDGE_FALL});
    wr(`VIC_OFF_REQ_CLR, 32'h3ff);
    step(4'b0010, 32'h000);
    step(4'b0000, 32'h008);
    step(4'b0100, 32'h200);
    step(4'b0000, 32'h000);
    step(4'b1000, 32'h002);
    step(4'b0000, 32'h002);
    pin <= 4'b0001;
    step(4'b0000, 32'h000);
    step(4'b0001, 32'h004);
    step(4'b0000, 32'h000);
    // slow sampling: a short pulse dies, a long one passes
    wr(`VIC_OFF_ESA, 32'h8);
    repeat (16) @(posedge aclk);
    wr(`VIC_OFF_REQ_CLR, 32'h3ff);
    pin <= 4'b0001;
    repeat (10) @(posedge aclk);
    step(4'b0000, 32'h000);
    pin <= 4'b0001;
    repeat (250) @(posedge aclk);
    step(4'b0000, 32'h004);
    repeat (250) @(posedge aclk);
    wr(`VIC_OFF_ESA, 32'h0);
    wr(`VIC_OFF_REQ_CLR, 32'h3ff);
    // all flags by software, levels 1 to 7 drained in fixed order by the cpu model
    wr(`VIC_OFF_REQ_SET, 32'h3ff);
    go <= 1'b1;
    master_enable(1'b1);
    for (int k = 1; k <= 7; k++) begin
      for (int j = 0; j < 100 && n_ff != 8'(k); j++) @(posedge aclk);
      chk(lvl_ff, k);
      chk(addr_ff, 2 * k);
    end
    repeat (10) @(posedge aclk);
    chk(vec_req_ff, 1'b0);
    rdc(`VIC_OFF_REQ, 32'h301);
    // shared vector with both sources enabled keeps both flags
    wr(`VIC_OFF_ENA_SET, 32'h1);
    wr(`VIC_OFF_REQ_SET, 32'h2);
    repeat (30) @(posedge aclk);
    go <= 1'b0;
    repeat (10) @(posedge aclk);
    chk(n_ff > 8'd8, 1'b1);
    chk(lvl_ff, 3'h1);
    rdc(`VIC_OFF_REQ, 32'h303);
    master_enable(1'b0);
    wr(`VIC_OFF_REQ_CLR, 32'h3ff);
    // enable gating, wake, set beating clear
    wr(`VIC_OFF_ENA_CLR, 32'h10);
    wr(`VIC_OFF_REQ_SET, 32'h10);
    rdc(`VIC_OFF_LINES, 32'h0);
    wr(`VIC_OFF_ENA_SET, 32'h10);
    rdc(`VIC_OFF_LINES, 32'h110);
    chk(vec_req_ff, 1'b0);
    wr(`VIC_OFF_REQ_CLR, 32'h10, 6'h02);
    rdc(`VIC_OFF_REQ, 32'h10);
    // high source only in status 1, none in status 2
    wr(`VIC_OFF_REQ_SET, 32'h4);
    wr(`VIC_OFF_PRI, 32'hc);
    rdc(`VIC_OFF_PRI, 32'hc);
    wr(`VIC_OFF_STS, 32'h1);
    repeat (2) @(posedge aclk);
    chk(vec_level_ff, 3'h4);
    chk(vec_addr_ff, `VIC_VEC_L4);
    wr(`VIC_OFF_STS, 32'h3);
    rdc(`VIC_OFF_STS, 32'h1);
    wr(`VIC_OFF_STS, 32'h2);
    repeat (2) @(posedge aclk);
    chk(vec_req_ff, 1'b0);
    wr(`VIC_OFF_STS, 32'h0);
    repeat (2) @(posedge aclk);
    chk(vec_level_ff, 3'h2);
    master_enable(1'b0);
    repeat (2) @(posedge aclk);
    chk(vec_req_ff, 1'b0);
    chk(wake_ff, 1'b1);
    summarize;
  end
endmodule // vic_top_tb
